// file: rtl/xce_exec.sv
// Notes on behaviour
// [RL1] Word 0014h is the accumulator call: no operands, flags untouched.
// [RL2] Call first pushes this instruction address plus 2 onto return stack.
// [RL3] Then the accumulator replaces the low program-counter byte.
// [RL4] High and upper latches load the high and upper counter bytes.
// [RL5] Call takes two cycles; the second idles while the target fetches.
// [RL6] Call leaves accumulator, status and bank select alone.
// [RL7] Indexed-to-absolute: EBh, bit 7 zero, offset; then Fh and 12-bit address.
// [RL8] Its source address is frame pointer plus the unsigned 7-bit offset.
// [RL9] Its destination is the 12-bit literal; anywhere in 000h to FFFh.
// [RL10] Writing counter low byte or stack-top bytes is unsupported by software.
// [RL11] A source on an indirect register reads as 00h.
// [RL12] Indexed-to-indexed with indirect destination writes nothing.
// [RL13] Indexed-to-indexed: EBh, bit 7 one, offset; then Fh, don't cares, offset.
// [RL14] Both its addresses are frame pointer plus offset in 4096 bytes.
// [RL15] Moves: read ends cycle one, write ends cycle two; pointer unchanged.
`timescale 1ns/10ps
`default_nettype none
module xce_exec
    import xce_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic instr_valid,
    input wire logic [15:0] instr_word,
    input wire logic [PC_W-1:0] instr_pc,
    input wire logic [7:0] accumulator_register,
    input wire logic [7:0] pc_high_latch,
    input wire logic [7:0] pc_upper_latch,
    input wire logic [DADDR_W-1:0] frame_pointer,
    input wire logic [7:0] mem_rdata,
    output logic exec_busy,
    output logic stack_push,
    output logic [PC_W-1:0] stack_push_addr,
    output logic pc_load,
    output logic [PC_W-1:0] pc_load_value,
    output logic mem_rd,
    output logic [DADDR_W-1:0] mem_raddr,
    output logic mem_wr,
    output logic [DADDR_W-1:0] mem_waddr,
    output logic [7:0] mem_wdata,
    output logic word_error
);
    if (PC_W < 17 || PC_W > 24) begin : g_pc_width_check
        $error("Counter width out of range");
    end

    xce_state_e state;
    logic move_indexed;
    logic src_indirect;
    logic [DADDR_W-1:0] calc_addr;
    logic calc_indirect;

    // One adder serves source in cycle one and destination in cycle two
    xce_addr_calc u_calc (
        .base(frame_pointer),
        .offset(instr_word[OFS_W-1:0]),
        .addr(calc_addr),
        .is_indirect(calc_indirect)
    );

    wire idle_take = (state == ST_IDLE) && instr_valid;
    // [RL1] call decode
    wire start_call = idle_take && (instr_word == OPC_CALL_ACC);
    // [RL7] [RL13] move decode
    wire start_move = idle_take && (instr_word[15:8] == OPC_MOVE_HI);
    wire word2_take = (state == ST_MOVE2) && instr_valid;
    wire word2_ok = word2_take && (instr_word[15:12] == OPC_WORD2_HI);

    // [RL5] two-cycle sequencing
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state <= ST_IDLE;
        end else begin
            unique case (state)
                ST_IDLE: begin
                    if (start_call) begin
                        state <= ST_CALL_NOP;
                    end else if (start_move) begin
                        state <= ST_MOVE2;
                    end
                end
                ST_CALL_NOP: begin
                    state <= ST_IDLE;
                end
                ST_MOVE2: begin
                    if (word2_take) begin
                        state <= ST_IDLE;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            exec_busy <= 1'b0;
        end else begin
            exec_busy <= start_call || start_move || ((state == ST_MOVE2) && !word2_take);
        end
    end

    // [RL2] return address push
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            stack_push <= 1'b0;
            stack_push_addr <= '0;
        end else begin
            stack_push <= start_call;
            if (start_call) begin
                stack_push_addr <= PC_W'(instr_pc + PC_STEP);
            end
        end
    end

    // [RL3] [RL4] target from accumulator and latches
    // [RL6] Only the counter and the return stack are driven; no other core state is
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            pc_load <= 1'b0;
            pc_load_value <= '0;
        end else begin
            pc_load <= start_call;
            if (start_call) begin
                pc_load_value <= {pc_upper_latch[PC_W-17:0], pc_high_latch,
                                  accumulator_register};
            end
        end
    end

    // [RL8] [RL14] source read held until the second word arrives
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            mem_rd <= 1'b0;
            mem_raddr <= '0;
            src_indirect <= 1'b0;
            move_indexed <= 1'b0;
        end else begin
            if (start_move) begin
                mem_rd <= 1'b1;
                mem_raddr <= calc_addr;
                src_indirect <= calc_indirect;
                move_indexed <= instr_word[MODE_BIT];
            end else if (word2_take) begin
                mem_rd <= 1'b0;
            end
        end
    end

    // [RL15] write one cycle after the read completes
    // [RL10] No guard on counter or stack-top targets; software avoids them
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            mem_wr <= 1'b0;
            mem_waddr <= '0;
            mem_wdata <= '0;
            word_error <= 1'b0;
        end else begin
            // [RL12] indirect destination of an indexed move suppresses write
            mem_wr <= word2_ok && !(move_indexed && calc_indirect);
            word_error <= word2_take && !word2_ok;
            if (word2_ok) begin
                // [RL9] absolute destination literal
                mem_waddr <= move_indexed ? calc_addr : instr_word[ABS_W-1:0];
                // [RL11] indirect source reads zero
                mem_wdata <= src_indirect ? IND_READ_VALUE : mem_rdata;
            end
        end
    end

    sequence seq_call_start;
        start_call;
    endsequence

    sequence seq_move_start;
        start_move;
    endsequence

    sequence seq_word2_accept;
        word2_ok;
    endsequence

    AST_CALL_PUSH: assert property (@(posedge sys_clk) disable iff (rst) // [RL2]
        seq_call_start |=> stack_push && stack_push_addr == PC_W'($past(instr_pc) + PC_STEP))
        else $error("Call pushed wrong return address");

    AST_CALL_TARGET: assert property (@(posedge sys_clk) disable iff (rst) // [RL3] [RL4]
        seq_call_start |=> pc_load && pc_load_value[7:0] == $past(accumulator_register)
            && pc_load_value[15:8] == $past(pc_high_latch)
            && pc_load_value[PC_W-1:16] == $past(pc_upper_latch[PC_W-17:0]))
        else $error("Call target bytes wrong");

    AST_CALL_TWO_CYCLES: assert property (@(posedge sys_clk) disable iff (rst) // [RL5]
        seq_call_start |=> exec_busy ##1 (!exec_busy && !pc_load && !stack_push))
        else $error("Call did not take two cycles");

    AST_SRC_ADDR: assert property (@(posedge sys_clk) disable iff (rst) // [RL8]
        seq_move_start |=> mem_rd && mem_raddr == DADDR_W'($past(frame_pointer)
            + {5'h00, $past(instr_word[6:0])}))
        else $error("Source address not pointer plus offset");

    AST_ABS_DEST: assert property (@(posedge sys_clk) disable iff (rst) // [RL9]
        seq_word2_accept ##0 !move_indexed |=> mem_wr && mem_waddr == $past(instr_word[11:0]))
        else $error("Absolute destination wrong");

    AST_IND_SRC_ZERO: assert property (@(posedge sys_clk) disable iff (rst) // [RL11]
        seq_word2_accept ##0 src_indirect |=> mem_wdata == 8'h00)
        else $error("Indirect source did not read zero");

    AST_IND_DST_NOP: assert property (@(posedge sys_clk) disable iff (rst) // [RL12]
        word2_take && move_indexed && calc_indirect |=> !mem_wr)
        else $error("Indirect destination was written");

    AST_MOVE_DATA: assert property (@(posedge sys_clk) disable iff (rst) // [RL15]
        seq_word2_accept ##0 !src_indirect |=> mem_wdata == $past(mem_rdata) ##1 !mem_wr)
        else $error("Move data or write pulse wrong");

    AST_NO_WRITE_BEFORE_WORD2: assert property (@(posedge sys_clk) disable iff (rst) // [RL15]
        seq_move_start |=> !mem_wr)
        else $error("Write before second word");
endmodule
`default_nettype wire

// file: rtl/xce_pkg.sv
package xce_pkg;
    // Instruction encodings
    localparam logic [15:0] OPC_CALL_ACC = 16'h0014;
    localparam logic [7:0] OPC_MOVE_HI = 8'hEB;
    localparam logic [3:0] OPC_WORD2_HI = 4'hF;
    localparam int MODE_BIT = 7;
    localparam int OFS_W = 7;
    localparam int ABS_W = 12;
    // Data space
    localparam int DADDR_W = 12;
    // Program counter
    localparam int PC_W = 21;
    localparam logic [PC_W-1:0] PC_STEP = 21'h000002;
    // Indirect access windows, each IND_SPAN addresses from its base
    localparam logic [DADDR_W-1:0] IND_BASE0 = 12'hFEB;
    localparam logic [DADDR_W-1:0] IND_BASE1 = 12'hFE3;
    localparam logic [DADDR_W-1:0] IND_BASE2 = 12'hFDB;
    localparam logic [DADDR_W-1:0] IND_SPAN = 12'h005;
    localparam logic [7:0] IND_READ_VALUE = 8'h00;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_CALL_NOP = 2'b01,
        ST_MOVE2 = 2'b10
    } xce_state_e;
endpackage

// file: rtl/xce_addr_calc.sv
`timescale 1ns/10ps
`default_nettype none
module xce_addr_calc
    import xce_pkg::*;
#(
    parameter int AW = DADDR_W,
    parameter int OW = OFS_W
) (
    input wire logic [AW-1:0] base,
    input wire logic [OW-1:0] offset,
    output logic [AW-1:0] addr,
    output logic is_indirect
);
    // Checked while the design is built, not when it runs
    if (OW >= AW) begin : g_width_check
        $error("Offset must be narrower than address");
    end

    // Wraps inside the data space
    assign addr = AW'(base + {{(AW-OW){1'b0}}, offset});

    always_comb begin
        is_indirect = 1'b0;
        if (addr >= IND_BASE0 && addr < AW'(IND_BASE0 + IND_SPAN)) is_indirect = 1'b1;
        if (addr >= IND_BASE1 && addr < AW'(IND_BASE1 + IND_SPAN)) is_indirect = 1'b1;
        if (addr >= IND_BASE2 && addr < AW'(IND_BASE2 + IND_SPAN)) is_indirect = 1'b1;
    end
endmodule
`default_nettype wire

// file: tb/xce_mem_model.sv
`timescale 1ns/10ps
`default_nettype none
module xce_mem_model
    import xce_pkg::*;
(
    input wire logic sys_clk,
    input wire logic mem_rd,
    input wire logic [DADDR_W-1:0] mem_raddr,
    output logic [7:0] mem_rdata
);
    logic [7:0] last_data = 8'h00;
    // Idle bus shows inverted last byte so stale data never matches
    always_comb begin
        if (mem_rd) begin
            mem_rdata = mem_raddr[7:0] ^ 8'hA5;
        end else begin
            mem_rdata = ~last_data;
        end
    end
    always_ff @(posedge sys_clk) begin
        last_data <= mem_rdata;
    end
endmodule
`default_nettype wire

// file: tb/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top
    import xce_pkg::*;
;
    logic sys_clk = 1'b0, rst = 1'b1, instr_valid = 1'b0;
    logic [15:0] instr_word = 16'h0000;
    logic [PC_W-1:0] instr_pc = '0;
    logic [7:0] acc = 8'h00, lat_hi = 8'h00, lat_up = 8'h00, mem_rdata;
    logic [DADDR_W-1:0] fp = '0, mem_raddr, mem_waddr;
    logic exec_busy, stack_push, pc_load, mem_rd, mem_wr, word_error;
    logic [PC_W-1:0] stack_push_addr, pc_load_value;
    logic [7:0] mem_wdata;
    int err_total = 0, tests_run = 0;
    xce_exec xce_exec_i (.sys_clk(sys_clk), .rst(rst), .instr_valid(instr_valid),
        .instr_word(instr_word), .instr_pc(instr_pc), .accumulator_register(acc),
        .pc_high_latch(lat_hi), .pc_upper_latch(lat_up), .frame_pointer(fp),
        .mem_rdata(mem_rdata), .exec_busy(exec_busy), .stack_push(stack_push),
        .stack_push_addr(stack_push_addr), .pc_load(pc_load),
        .pc_load_value(pc_load_value), .mem_rd(mem_rd), .mem_raddr(mem_raddr),
        .mem_wr(mem_wr), .mem_waddr(mem_waddr), .mem_wdata(mem_wdata),
        .word_error(word_error));
    xce_mem_model xce_mem_model_i (.sys_clk(sys_clk), .mem_rd(mem_rd),
        .mem_raddr(mem_raddr), .mem_rdata(mem_rdata));
    initial begin
        forever #10 sys_clk = ~sys_clk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic give_verdict();
        $display("compares %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic do_call(input logic [20:0] pc, input logic [7:0] a, h, u,
                           input logic [20:0] push, load);
        @(negedge sys_clk);
        instr_pc = pc;
        acc = a;
        lat_hi = h;
        lat_up = u;
        instr_valid = 1'b1;
        instr_word = OPC_CALL_ACC;
        @(negedge sys_clk);
        chk(stack_push, 1);
        chk(stack_push_addr, push);
        chk(pc_load, 1);
        chk(pc_load_value, load);
        chk(exec_busy, 1);
        chk(mem_rd, 0);
        chk(mem_wr, 0);
        // Word offered in the idle cycle must be ignored
        @(negedge sys_clk);
        instr_valid = 1'b0;
        chk(stack_push, 0);
        chk(pc_load, 0);
        chk(exec_busy, 0);
        $display("call test done pc %h", pc);
    endtask
    task automatic do_move(input logic [15:0] w1, w2, input logic [11:0] f, ra,
                           input logic wr, err, input logic [11:0] wa, input logic [7:0] wd);
        @(negedge sys_clk);
        fp = f;
        instr_valid = 1'b1;
        instr_word = w1;
        instr_pc = 21'h000200;
        @(negedge sys_clk);
        chk(mem_rd, 1);
        chk(mem_raddr, ra);
        // Busy while the second word is still owed
        chk(exec_busy, 1);
        instr_word = w2;
        @(negedge sys_clk);
        instr_valid = 1'b0;
        chk(mem_rd, 0);
        chk(mem_wr, wr);
        chk(word_error, err);
        chk(exec_busy, 0);
        if (wr) begin
            chk(mem_waddr, wa);
            chk(mem_wdata, wd);
        end
        @(negedge sys_clk);
        chk(mem_wr, 0);
        chk(stack_push, 0);
        $display("move test done %h %h", w1, w2);
    endtask
    task automatic do_unknown_words();
        @(negedge sys_clk);
        instr_valid = 1'b1;
        instr_word = 16'h0015;
        @(negedge sys_clk);
        chk(stack_push, 0);
        chk(pc_load, 0);
        chk(exec_busy, 0);
        instr_word = 16'hEA05;
        @(negedge sys_clk);
        instr_valid = 1'b0;
        chk(mem_rd, 0);
        chk(exec_busy, 0);
        $display("unknown words test done");
    endtask
    task automatic do_move_late();
        @(negedge sys_clk);
        fp = 12'h080;
        instr_valid = 1'b1;
        instr_word = 16'hEB05;
        @(negedge sys_clk);
        instr_valid = 1'b0;
        chk(mem_rd, 1);
        // Read must stay up while the second word is late
        @(negedge sys_clk);
        chk(exec_busy, 1);
        chk(mem_rd, 1);
        chk(mem_raddr, 12'h085);
        chk(mem_wr, 0);
        instr_valid = 1'b1;
        instr_word = 16'hF044;
        @(negedge sys_clk);
        instr_valid = 1'b0;
        chk(exec_busy, 0);
        chk(mem_wr, 1);
        chk(mem_waddr, 12'h044);
        chk(mem_wdata, 8'h20);
        $display("late second word test done");
    endtask
    task automatic do_mid_reset();
        @(negedge sys_clk);
        fp = 12'h080;
        instr_valid = 1'b1;
        instr_word = 16'hEB05;
        @(negedge sys_clk);
        rst = 1'b1;
        instr_valid = 1'b0;
        chk(mem_rd, 1);
        @(negedge sys_clk);
        chk(mem_rd, 0);
        chk(mem_raddr, 12'h000);
        chk(exec_busy, 0);
        // A stray second word after reset must not finish the move
        rst = 1'b0;
        instr_valid = 1'b1;
        instr_word = 16'hF123;
        @(negedge sys_clk);
        instr_valid = 1'b0;
        chk(mem_wr, 0);
        chk(word_error, 0);
        chk(exec_busy, 0);
        $display("mid-run reset test done");
    endtask
    initial begin
        repeat (12) @(posedge sys_clk);
        @(negedge sys_clk);
        rst = 1'b0;
        chk(exec_busy, 0);
        chk(mem_wr, 0);
        chk(stack_push, 0);
        do_call(21'h000100, 8'h06, 8'h10, 8'h00, 21'h000102, 21'h001006);
        do_call(21'h1FFFFC, 8'hFF, 8'hAB, 8'hFF, 21'h1FFFFE, 21'h1FABFF);
        do_move(16'hEB05, 16'hF123, 12'h080, 12'h085, 1, 0, 12'h123, 8'h20);
        do_move(16'hEB85, 16'hFF86, 12'h080, 12'h085, 1, 0, 12'h086, 8'h20);
        do_move(16'hEB0B, 16'hF010, 12'hFE0, 12'hFEB, 1, 0, 12'h010, 8'h00);
        do_move(16'hEB85, 16'hF06B, 12'hF80, 12'hF85, 0, 0, 12'h000, 8'h00);
        do_move(16'hEB7F, 16'hF200, 12'hFFF, 12'h07E, 1, 0, 12'h200, 8'hDB);
        do_move(16'hEBFF, 16'hF07F, 12'hF81, 12'h000, 1, 0, 12'h000, 8'hA5);
        do_move(16'hEB01, 16'hFFEB, 12'h000, 12'h001, 1, 0, 12'hFEB, 8'hA4);
        do_move(16'hEB01, 16'h0123, 12'h000, 12'h001, 0, 1, 12'h000, 8'h00);
        do_unknown_words();
        do_move_late();
        do_mid_reset();
        give_verdict();
    end
endmodule
`default_nettype wire
